// file: logic/pgdc_consts.vh
// register addresses, reset values and pin masks for the port group direction block
`ifndef PGDC_CONSTS_VH
`define PGDC_CONSTS_VH
`define PGDC_ADDR_W 20
`define PGDC_DIR0_ADDR 20'hFFF20
`define PGDC_DIR1_ADDR 20'hFFF21
`define PGDC_DIR2_ADDR 20'hFFF22
`define PGDC_DIR3_ADDR 20'hFFF23
`define PGDC_DIR4_ADDR 20'hFFF24
`define PGDC_DIR5_ADDR 20'hFFF25
`define PGDC_DIR6_ADDR 20'hFFF26
`define PGDC_DIR7_ADDR 20'hFFF27
`define PGDC_DIR12_ADDR 20'hFFF2C
`define PGDC_DIR14_ADDR 20'hFFF2E
`define PGDC_DIR15_ADDR 20'hFFF2F
`define PGDC_DATA12_ADDR 20'hFFF0C
`define PGDC_DATA13_ADDR 20'hFFF0D
`define PGDC_DATA14_ADDR 20'hFFF0E
`define PGDC_DATA15_ADDR 20'hFFF0F
`define PGDC_PORT_TWELVE_PULLUP_REG_ADDR 20'hF003C
`define PGDC_PORT_FOURTEEN_PULLUP_REG_ADDR 20'hF003E
`define PGDC_AS12_ADDR 20'hF006C
`define PGDC_CPC_ADDR 20'hF0076
`define PGDC_DIR_RST 8'hFF
`define PGDC_DATA_RST 8'h00
`define PGDC_PU_RST 8'h00
`define PGDC_AS_RST 8'hFF
`define PGDC_CPC_RST 8'h00
`define PGDC_MASK0 8'h7F
`define PGDC_MASK1 8'h7F
`define PGDC_MASK2 8'hFF
`define PGDC_MASK3 8'h03
`define PGDC_MASK4 8'h0F
`define PGDC_MASK5 8'h03
`define PGDC_MASK6 8'h0F
`define PGDC_MASK7 8'hFF
`define PGDC_MASK12 8'h01
`define PGDC_MASK14 8'h03
`define PGDC_MASK15 8'h1F
`define PGDC_CHAN_FIRST15 4'h8
`define PGDC_CHAN_W 4
`endif

// file: logic/pgdc_dir_reg.v
// one port direction register with hardwired input positions
`timescale 1ns/10ps
`default_nettype none
module pgdc_dir_reg #(
    parameter [7:0] MASK = 8'hFF,
    parameter [7:0] RST = 8'hFF
) (
    input wire clk_sys,
    input wire rst_n,
    input wire sel,
    input wire wr_en,
    input wire [7:0] wr_be,
    input wire [7:0] wr_data,
    output wire [7:0] dir
);
    reg [7:0] dir_r;
    wire [7:0] dir_nxt;
    assign dir_nxt = (dir_r & ~wr_be) | (wr_data & wr_be);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= RST;
        end else if (sel && wr_en) begin
            dir_r <= dir_nxt;
        end
    end
    assign dir = dir_r | ~MASK;
endmodule
`default_nettype wire

// file: logic/pgdc_sync.v
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pgdc_sync #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule
`default_nettype wire

// file: logic/pgdc_top.v
// port group direction control: direction registers and ports 12 to 15
`timescale 1ns/10ps
`default_nettype none
`include "pgdc_consts.vh"
module pgdc_top #(
    parameter [7:0] PKG_MASK12 = `PGDC_MASK12,
    parameter [7:0] PKG_MASK14 = `PGDC_MASK14,
    parameter [7:0] PKG_MASK15 = `PGDC_MASK15
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [19:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_rd,
    input wire cpu_bit_op,
    input wire [2:0] cpu_bit_sel,
    input wire [7:0] cpu_wdata,
    output reg [7:0] cpu_rdata,
    input wire [3:0] converter_channel_selector,
    input wire pt12_pin0_in,
    output wire pt12_pin0_out,
    output wire pt12_pin0_oe_n,
    output wire pt12_pin0_pullup,
    output wire pt12_pin0_analog,
    input wire [3:0] pt12_in_pins,
    output wire pt13_out_pin,
    input wire pt13_in_pin,
    input wire [1:0] pt14_pin_in,
    output wire [1:0] pt14_pin_out,
    output wire [1:0] pt14_pin_oe_n,
    output wire [1:0] pt14_pin_pullup,
    input wire [4:0] pt15_pin_in,
    output wire [4:0] pt15_pin_out,
    output wire [4:0] pt15_pin_oe_n,
    output wire [4:0] pt15_pin_analog,
    output wire [4:0] pt15_convert_sel,
    output wire [63:0] low_port_dir
);
    reg rst_s1_r;
    reg rst_n_r;
    wire rst_n;
    wire [7:0] be;
    wire wr_any;
    wire [7:0] dir12;
    wire [7:0] dir14;
    wire [7:0] dir15;
    reg [7:0] lat12_r;
    reg lat13_r;
    reg [7:0] lat14_r;
    reg [7:0] lat15_r;
    reg [7:0] port_twelve_pullup_reg_r;
    reg [7:0] port_fourteen_pullup_reg_r;
    reg [7:0] as12_r;
    reg [7:0] cpc_r;
    wire [4:0] p12_sync;
    wire p13_sync;
    wire [1:0] p14_sync;
    wire [4:0] p15_sync;
    wire [4:0] an15;
    wire [7:0] rd12;
    wire [7:0] rd13;
    wire [7:0] rd14;
    wire [7:0] rd15;
    wire [63:0] low_dir;
    reg [7:0] rd_mux;
    reg rd_hit;
    genvar g;

    // reset release through two flops
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_n_r;

    // byte lanes of a one-bit or whole-byte access
    function [7:0] lane_mask;
        input bit_op;
        input [2:0] sel;
        begin
            if (bit_op) begin
                lane_mask = 8'h01 << sel;
            end else begin
                lane_mask = 8'hFF;
            end
        end
    endfunction

    function hit;
        input [19:0] a;
        input [19:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign be = lane_mask(cpu_bit_op, cpu_bit_sel);
    assign wr_any = cpu_wr;

    // direction registers, ports 0 to 7
    generate
        for (g = 0; g < 8; g = g + 1) begin : low_dir_gen
            localparam [7:0] MK = (g == 0) ? `PGDC_MASK0 : (g == 1) ? `PGDC_MASK1 :
                (g == 2) ? `PGDC_MASK2 : (g == 3) ? `PGDC_MASK3 :
                (g == 4) ? `PGDC_MASK4 : (g == 5) ? `PGDC_MASK5 :
                (g == 6) ? `PGDC_MASK6 : `PGDC_MASK7;
            // full-width sum, cut to the bus width on purpose
            localparam [31:0] AD32 = `PGDC_DIR0_ADDR + g;
            pgdc_dir_reg #(.MASK(MK), .RST(`PGDC_DIR_RST)) u_dir (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .sel(hit(cpu_addr, AD32[19:0])),
                .wr_en(wr_any),
                .wr_be(be),
                .wr_data(cpu_wdata),
                .dir(low_dir[8*g+7:8*g])
            );
        end
    endgenerate
    assign low_port_dir = low_dir;

    pgdc_dir_reg #(.MASK(PKG_MASK12), .RST(`PGDC_DIR_RST)) u_dir12 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sel(hit(cpu_addr, `PGDC_DIR12_ADDR)),
        .wr_en(wr_any),
        .wr_be(be),
        .wr_data(cpu_wdata),
        .dir(dir12)
    );
    pgdc_dir_reg #(.MASK(PKG_MASK14), .RST(`PGDC_DIR_RST)) u_dir14 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sel(hit(cpu_addr, `PGDC_DIR14_ADDR)),
        .wr_en(wr_any),
        .wr_be(be),
        .wr_data(cpu_wdata),
        .dir(dir14)
    );
    pgdc_dir_reg #(.MASK(PKG_MASK15), .RST(`PGDC_DIR_RST)) u_dir15 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sel(hit(cpu_addr, `PGDC_DIR15_ADDR)),
        .wr_en(wr_any),
        .wr_be(be),
        .wr_data(cpu_wdata),
        .dir(dir15)
    );

    // latches, pull-up and analog select registers
    always @(posedge clk_sys or negedge rst_n) begin
        // latches, pull-ups, analog select and converter config reset
        if (!rst_n) begin
            lat12_r <= `PGDC_DATA_RST;
            lat13_r <= 1'b0;
            lat14_r <= `PGDC_DATA_RST;
            lat15_r <= `PGDC_DATA_RST;
            port_twelve_pullup_reg_r <= `PGDC_PU_RST;
            port_fourteen_pullup_reg_r <= `PGDC_PU_RST;
            as12_r <= `PGDC_AS_RST;
            cpc_r <= `PGDC_CPC_RST;
        end else if (cpu_wr) begin
            // port 12 pin 0 latch only
            if (hit(cpu_addr, `PGDC_DATA12_ADDR)) begin
                lat12_r <= ((lat12_r & ~be) | (cpu_wdata & be)) & 8'h01;
            end
            if (hit(cpu_addr, `PGDC_DATA13_ADDR) && be[0]) begin
                lat13_r <= cpu_wdata[0];
            end
            if (hit(cpu_addr, `PGDC_DATA14_ADDR)) begin
                lat14_r <= ((lat14_r & ~be) | (cpu_wdata & be)) & PKG_MASK14;
            end
            if (hit(cpu_addr, `PGDC_DATA15_ADDR)) begin
                lat15_r <= ((lat15_r & ~be) | (cpu_wdata & be)) & PKG_MASK15;
            end
            if (hit(cpu_addr, `PGDC_PORT_TWELVE_PULLUP_REG_ADDR)) begin
                port_twelve_pullup_reg_r <= ((port_twelve_pullup_reg_r & ~be) | (cpu_wdata & be)) & PKG_MASK12;
            end
            if (hit(cpu_addr, `PGDC_PORT_FOURTEEN_PULLUP_REG_ADDR)) begin
                port_fourteen_pullup_reg_r <= ((port_fourteen_pullup_reg_r & ~be) | (cpu_wdata & be)) & PKG_MASK14;
            end
            // analog select, unused bits stay one
            if (hit(cpu_addr, `PGDC_AS12_ADDR)) begin
                as12_r <= ((as12_r & ~be) | (cpu_wdata & be)) | ~PKG_MASK12;
            end
            // byte writes only for converter config
            if (hit(cpu_addr, `PGDC_CPC_ADDR) && !cpu_bit_op) begin
                cpc_r <= {4'h0, cpu_wdata[3:0]};
            end
        end
    end

    // pins cross into clk_sys through two flops
    pgdc_sync #(.W(13)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({pt15_pin_in, pt14_pin_in, pt13_in_pin, pt12_in_pins, pt12_pin0_in}),
        .q({p15_sync, p14_sync, p13_sync, p12_sync})
    );

    // pin 0 drive, zero means output
    assign pt12_pin0_out = lat12_r[0];
    assign pt12_pin0_oe_n = dir12[0] | as12_r[0];
    assign pt12_pin0_analog = as12_r[0];
    assign pt12_pin0_pullup = port_twelve_pullup_reg_r[0] & dir12[0] & ~as12_r[0];

    // latch cleared by reset, so pin falls low
    assign pt13_out_pin = lat13_r;

    assign pt14_pin_out = lat14_r[1:0];
    assign pt14_pin_oe_n = dir14[1:0];
    assign pt14_pin_pullup = port_fourteen_pullup_reg_r[1:0] & dir14[1:0];

    // pins in analog mode: all when converter config is 0, none for 1 to 8, else those with index below the config minus 8
    generate
        for (g = 0; g < 5; g = g + 1) begin : p15_gen
            localparam [31:0] CH32 = `PGDC_CHAN_FIRST15 + g;
            // analog pins taken from the low end
            assign an15[g] = (cpc_r[3:0] == 4'h0) ? 1'b1 :
                (cpc_r[3:0] <= 4'h8) ? 1'b0 : (g < cpc_r[3:0] - 4'h8);
            assign pt15_convert_sel[g] = an15[g] & dir15[g] & PKG_MASK15[g] &
                (converter_channel_selector == CH32[3:0]);
        end
    endgenerate
    assign pt15_pin_analog = an15;
    assign pt15_pin_out = lat15_r[4:0];
    // analog plus output is forbidden; driver kept off as a safe answer
    assign pt15_pin_oe_n = dir15[4:0] | an15;

    // pin level in input, latch in output; analog reads zero
    // pins 1 to 4 read only
    assign rd12 = {3'h0, p12_sync[4:1] & PKG_MASK12[4:1] | p12_sync[4:1],
        dir12[0] ? (p12_sync[0] & ~as12_r[0]) : lat12_r[0]};
    // pin 7 level, pin 0 latch
    assign rd13 = {p13_sync, 6'h00, lat13_r};
    assign rd14 = {6'h00, (dir14[1:0] & p14_sync) | (~dir14[1:0] & lat14_r[1:0])};
    assign rd15 = {3'h0, (dir15[4:0] & p15_sync & ~an15) | (~dir15[4:0] & lat15_r[4:0])};

    always @* begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        case (cpu_addr)
            `PGDC_DIR0_ADDR: rd_mux = low_dir[7:0];
            `PGDC_DIR1_ADDR: rd_mux = low_dir[15:8];
            `PGDC_DIR2_ADDR: rd_mux = low_dir[23:16];
            `PGDC_DIR3_ADDR: rd_mux = low_dir[31:24];
            `PGDC_DIR4_ADDR: rd_mux = low_dir[39:32];
            `PGDC_DIR5_ADDR: rd_mux = low_dir[47:40];
            `PGDC_DIR6_ADDR: rd_mux = low_dir[55:48];
            `PGDC_DIR7_ADDR: rd_mux = low_dir[63:56];
            `PGDC_DIR12_ADDR: rd_mux = dir12;
            `PGDC_DIR14_ADDR: rd_mux = dir14;
            `PGDC_DIR15_ADDR: rd_mux = dir15;
            `PGDC_DATA12_ADDR: rd_mux = rd12;
            `PGDC_DATA13_ADDR: rd_mux = rd13;
            `PGDC_DATA14_ADDR: rd_mux = rd14;
            `PGDC_DATA15_ADDR: rd_mux = rd15;
            `PGDC_PORT_TWELVE_PULLUP_REG_ADDR: rd_mux = port_twelve_pullup_reg_r;
            `PGDC_PORT_FOURTEEN_PULLUP_REG_ADDR: rd_mux = port_fourteen_pullup_reg_r;
            `PGDC_AS12_ADDR: rd_mux = as12_r;
            `PGDC_CPC_ADDR: rd_mux = cpc_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // registered read data; unmapped reads zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            cpu_rdata <= rd_hit ? rd_mux : 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: test/pgdc_board.sv
// board-side model of the pins: driven level, external source, pull-up or float
`timescale 1ns/10ps
`default_nettype none
module pgdc_board #(parameter int W = 1) (
    input wire logic clk_sys,
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pu_on,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    // floating pin toggles so a stale level is never read back
    logic [W-1:0] tgl = '0;
    always @(posedge clk_sys) tgl <= ~tgl;
    // driver first, then board source, then pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n[i]) pin[i] = out[i];
            else if (ext_en[i]) pin[i] = ext[i];
            else if (pu_on[i]) pin[i] = 1'b1;
            else pin[i] = tgl[i];
        end
    end
endmodule
`default_nettype wire

// file: test/pgdc_top_chk.sv
// port-level assertions for the port group direction block
`timescale 1ns/10ps
`default_nettype none
`include "pgdc_consts.vh"
module pgdc_top_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [19:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic [3:0] converter_channel_selector,
    input wire logic pt12_pin0_oe_n,
    input wire logic pt12_pin0_pullup,
    input wire logic pt12_pin0_analog,
    input wire logic pt13_out_pin,
    input wire logic [1:0] pt14_pin_oe_n,
    input wire logic [1:0] pt14_pin_pullup,
    input wire logic [4:0] pt15_pin_oe_n,
    input wire logic [4:0] pt15_pin_analog,
    input wire logic [4:0] pt15_convert_sel,
    input wire logic [63:0] low_port_dir
);
    localparam logic [63:0] PM = {`PGDC_MASK7, `PGDC_MASK6, `PGDC_MASK5, `PGDC_MASK4,
        `PGDC_MASK3, `PGDC_MASK2, `PGDC_MASK1, `PGDC_MASK0};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    AST_P13_RST_LOW: assert property (@(posedge clk_sys) disable iff (1'b0)
        !reset_n |-> !pt13_out_pin) else $error("port 13 output high in reset");
    AST_RST_STATE: assert property ($rose(reset_n) |-> low_port_dir == '1
        && pt14_pin_oe_n == 2'h3 && pt15_pin_oe_n == 5'h1F && pt15_pin_analog == 5'h1F
        && pt12_pin0_analog) else $error("state after reset wrong");
    AST_ABSENT_ONE: assert property ((low_port_dir | PM) == '1)
        else $error("absent direction bit not one");
    AST_P15_ANA_OFF: assert property ((pt15_pin_analog & ~pt15_pin_oe_n) == 5'h00)
        else $error("analog port 15 pin driving");
    AST_P12_ANA_OFF: assert property (pt12_pin0_analog |-> pt12_pin0_oe_n)
        else $error("analog port 12 pin driving");
    AST_P12_PU: assert property (pt12_pin0_pullup |-> pt12_pin0_oe_n && !pt12_pin0_analog)
        else $error("port 12 pull-up outside digital input");
    AST_P14_PU: assert property ((pt14_pin_pullup & ~pt14_pin_oe_n) == 2'h0)
        else $error("port 14 pull-up on output");
    AST_CONV: assert property (pt15_convert_sel != 5'h00 |->
        pt15_convert_sel == (5'h01 << (converter_channel_selector - 4'h8))
        && (pt15_convert_sel & ~(pt15_pin_analog & pt15_pin_oe_n)) == 5'h00)
        else $error("conversion select wrong");
    AST_RD_HOLD: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data changed without read");
    AST_UNMAPPED: assert property (cpu_rd && cpu_addr == 20'hFFF28 |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (pt15_convert_sel != 5'h00);
    cover property (pt14_pin_pullup == 2'h3);
    cover property ($rose(pt13_out_pin));
endmodule
bind pgdc_top pgdc_top_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .converter_channel_selector(converter_channel_selector),
    .pt12_pin0_oe_n(pt12_pin0_oe_n), .pt12_pin0_pullup(pt12_pin0_pullup),
    .pt12_pin0_analog(pt12_pin0_analog), .pt13_out_pin(pt13_out_pin),
    .pt14_pin_oe_n(pt14_pin_oe_n), .pt14_pin_pullup(pt14_pin_pullup),
    .pt15_pin_oe_n(pt15_pin_oe_n), .pt15_pin_analog(pt15_pin_analog),
    .pt15_convert_sel(pt15_convert_sel), .low_port_dir(low_port_dir));
`default_nettype wire

// file: test/port_group_direction_control_tb.sv
// self-checking bench for the port group direction block
`timescale 1ns/10ps
`default_nettype none
`include "pgdc_consts.vh"
module port_group_direction_control_tb;
    logic clk_sys = 0, reset_n = 1, cpu_wr = 0, cpu_rd = 0, cpu_bit_op = 0, p13_in = 0;
    logic [19:0] cpu_addr = 0;
    logic [2:0] cpu_bit_sel = 0;
    logic [7:0] cpu_wdata = 0, cpu_rdata;
    logic [3:0] sel = 0, p12_hi = 0;
    logic p12_in, p12_out, p12_oe_n, p12_pu, p12_an, p13_out, e12_en = 0, e12 = 0;
    logic [1:0] p14_in, p14_out, p14_oe_n, p14_pu, e14_en = 0, e14 = 0;
    logic [4:0] p15_in, p15_out, p15_oe_n, p15_an, p15_cv, e15_en = 0, e15 = 0;
    logic [63:0] low_dir;
    int n_fail = 0, checks = 0;
    localparam logic [19:0] DIRS[11] = '{20'hFFF20, 20'hFFF21, 20'hFFF22, 20'hFFF23,
        20'hFFF24, 20'hFFF25, 20'hFFF26, 20'hFFF27, 20'hFFF2C, 20'hFFF2E, 20'hFFF2F};
    localparam logic [35:0] ROWS[8] = '{{20'hFFF20, 16'h0080}, {20'hFFF23, 16'h00FC},
        {20'hFFF27, 16'h5A5A}, {20'hFFF26, 16'hA5F5}, {20'hFFF2C, 16'h00FE},
        {20'hFFF2E, 16'h00FC}, {20'hFFF2F, 16'h00E0}, {20'hFFF28, 16'h5500}};
    always #5 clk_sys = ~clk_sys;
    pgdc_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .converter_channel_selector(sel),
        .pt12_pin0_in(p12_in), .pt12_pin0_out(p12_out), .pt12_pin0_oe_n(p12_oe_n),
        .pt12_pin0_pullup(p12_pu), .pt12_pin0_analog(p12_an), .pt12_in_pins(p12_hi),
        .pt13_out_pin(p13_out), .pt13_in_pin(p13_in), .pt14_pin_in(p14_in),
        .pt14_pin_out(p14_out), .pt14_pin_oe_n(p14_oe_n), .pt14_pin_pullup(p14_pu),
        .pt15_pin_in(p15_in), .pt15_pin_out(p15_out), .pt15_pin_oe_n(p15_oe_n),
        .pt15_pin_analog(p15_an), .pt15_convert_sel(p15_cv), .low_port_dir(low_dir));
    pgdc_board #(.W(1)) b12 (.clk_sys(clk_sys), .oe_n(p12_oe_n), .out(p12_out),
        .pu_on(p12_pu), .ext_en(e12_en), .ext(e12), .pin(p12_in));
    pgdc_board #(.W(2)) b14 (.clk_sys(clk_sys), .oe_n(p14_oe_n), .out(p14_out),
        .pu_on(p14_pu), .ext_en(e14_en), .ext(e14), .pin(p14_in));
    pgdc_board #(.W(5)) b15 (.clk_sys(clk_sys), .oe_n(p15_oe_n), .out(p15_out),
        .pu_on(5'h00), .ext_en(e15_en), .ext(e15), .pin(p15_in));
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus cycle: strobe held across exactly one rising edge
    task automatic acc(input logic [19:0] a, input logic w, input logic b, input logic [2:0] s,
        input logic [7:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_wr = w;
        cpu_rd = !w;
        cpu_bit_op = b;
        cpu_bit_sel = s;
        cpu_wdata = d;
        @(negedge clk_sys);
        cpu_wr = 0;
        cpu_rd = 0;
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        acc(a, 1, 0, 0, d);
    endtask
    task automatic rdc(input logic [19:0] a, input logic [7:0] e);
        acc(a, 0, 0, 0, 0);
        chk("rdata", cpu_rdata, e);
    endtask
    initial begin
        #300000;
        n_fail++;
        test_done();
    end
    initial begin
        // a real falling edge, so the async reset acts before the first clock
        #1 reset_n = 0;
        repeat (12) @(negedge clk_sys);
        chk("p13_out", p13_out, 0);
        chk("low_dir", low_dir, '1);
        chk("oe_n", {p14_oe_n, p15_oe_n, p15_an, p12_an}, 13'h1FFF);
        reset_n = 1;
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 11; i++) rdc(DIRS[i], 8'hFF);
        acc(20'hFFF2E, 1, 1, 3'd1, 8'h00);
        rdc(20'hFFF2E, 8'hFD);
        for (int i = 0; i < 8; i++) begin
            wr(ROWS[i][35:16], ROWS[i][15:8]);
            rdc(ROWS[i][35:16], ROWS[i][7:0]);
        end
        chk("low_dir", low_dir, 64'h5AF5FFFFFCFFFF80);
        chk("p15_oe_n", p15_oe_n, 5'h1F);
        wr(20'hFFF0E, 8'h02);
        chk("p14", {p14_out, p14_oe_n}, 4'h8);
        rdc(20'hFFF0E, 8'h02);
        wr(20'hF003E, 8'h03);
        chk("p14_pu", p14_pu, 2'h0);
        wr(20'hFFF2E, 8'hFF);
        e14_en = 2'h3;
        e14 = 2'h1;
        chk("p14_pu", p14_pu, 2'h3);
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF0E, 8'h01);
        wr(20'hFFF2F, 8'hFF);
        e15_en = 5'h1F;
        e15 = 5'h1F;
        sel = 4'h8;
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF0F, 8'h00);
        chk("p15_cv", p15_cv, 5'h01);
        wr(20'hF0076, 8'h09);
        chk("p15_an", p15_an, 5'h01);
        rdc(20'hFFF0F, 8'h1E);
        sel = 4'h9;
        #1 chk("p15_cv", p15_cv, 5'h00);
        wr(20'hFFF0F, 8'h1E);
        wr(20'hFFF2F, 8'h01);
        chk("p15", {p15_out, p15_oe_n}, 10'h3C1);
        p12_hi = 4'hA;
        e12_en = 1;
        e12 = 1;
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF0C, 8'h14);
        wr(20'hF006C, 8'h00);
        chk("p12", {p12_an, p12_oe_n}, 2'h0);
        wr(20'hFFF0C, 8'h01);
        chk("p12_out", p12_out, 1);
        rdc(20'hFFF0C, 8'h15);
        wr(20'hF003C, 8'h01);
        chk("p12_pu", p12_pu, 0);
        wr(20'hFFF2C, 8'hFF);
        chk("p12_pu", p12_pu, 1);
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF0C, 8'h15);
        wr(20'hF006C, 8'h01);
        chk("p12_pu", p12_pu, 0);
        rdc(20'hFFF0C, 8'h14);
        p13_in = 1;
        wr(20'hFFF0D, 8'h01);
        chk("p13_out", p13_out, 1);
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF0D, 8'h81);
        reset_n = 0;
        #1 chk("p13_out", p13_out, 0);
        chk("rst", {low_dir, p15_an}, {64'hFFFFFFFFFFFFFFFF, 5'h1F});
        repeat (2) @(negedge clk_sys);
        reset_n = 1;
        repeat (3) @(negedge clk_sys);
        rdc(20'hFFF2F, 8'hFF);
        test_done();
    end
endmodule
`default_nettype wire
